// file: verilog/dts_top.sv
/*
  drive timing supervisor: run-duration timer, run-time flag, analog
  window, heatsink threshold, fan control, dormant and wakeup control,
  with an apb register file and one level interrupt.
  assumes drive inputs are pins (synchronised here) and pclk is 20 mhz.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [R1] with the timer enabled, run duration is counted from each start; disabled, no timing.
// [R2] when the counted duration reaches the set duration the drive stops and timing_reached rises.
// [R3] the timer restarts at zero each start and the time left is readable.
// [R4] source 0 takes the duration register, 1 to 3 scale it by analog input one to three.
// [R5] duration is held in tenths of a minute, clamped to 6500.0, resetting to zero.
// [R6] analog one out-of-limit is high above the upper or below the lower limit.
// [R7] module temperature flag is high once heatsink reaches the threshold.
// [R8] fan mode 0 runs the fan while running, else by heatsink above or below 40 degc.
// [R9] fan mode 1 runs the fan always from power-on.
// [R10] running with set frequency at or below sleep frequency for the sleep delay stops into dormant.
// [R11] dormant with run command and set frequency at or above wake frequency for wake delay restarts.
// [R12] wake and sleep frequency both zero disables dormant and wakeup.
// [R13] software should keep wake frequency at or above sleep frequency; sleep is clamped to it.
// [R14] run_time_reached rises once the current run time reaches the target.
// [R15] all delay counters step on one prescaled tenth-second tick and its tenth-minute divide.
module dts_top #(
  parameter int TICK_CYC = dts_pkg::TENTH_SEC_CYC
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side
  input wire dts_pkg::dts_drive_s drive_in,
  output dts_pkg::dts_flags_s flags_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  dts_pkg::dts_drive_s sync1_r;
  dts_pkg::dts_drive_s drv_r;

  // two flops ahead of any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      drv_r <= '0;
    end else begin
      sync1_r <= drive_in;
      drv_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] tmr_en_r, tmr_src_r, tmr_dur_r, ai_lo_r, ai_hi_r, hs_thr_r;
  logic [15:0] fan_mode_r, wake_f_r, wake_d_r, sleep_f_r, sleep_d_r;
  logic [15:0] run_tgt_r;
  logic [8:0] irq_stat_r, irq_mask_r;
  logic [15:0] remain_r;
  dts_pkg::dts_flags_s fl_r;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] hi);
    clamp16 = (v > hi) ? hi : v;
  endfunction

  function automatic logic [15:0] clamp_lo(input logic [15:0] v,
                                           input logic [15:0] lo);
    clamp_lo = (v < lo) ? lo : v;
  endfunction

  // bus decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire [15:0] wd = pwdata[15:0];
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= dts_pkg::OFS_IRQ_MASK);
  wire stat_rd = rd_en && (paddr == dts_pkg::OFS_IRQ_STAT);

  // write side of the register file, with range clamps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_en_r <= dts_pkg::RST_ZERO;
      tmr_src_r <= dts_pkg::RST_ZERO;
      tmr_dur_r <= dts_pkg::RST_ZERO;
      ai_lo_r <= dts_pkg::RST_AI1_LO;
      ai_hi_r <= dts_pkg::RST_AI1_HI;
      hs_thr_r <= dts_pkg::RST_HS_THR;
      fan_mode_r <= dts_pkg::RST_ZERO;
      wake_f_r <= dts_pkg::RST_ZERO;
      wake_d_r <= dts_pkg::RST_ZERO;
      sleep_f_r <= dts_pkg::RST_ZERO;
      sleep_d_r <= dts_pkg::RST_ZERO;
      run_tgt_r <= dts_pkg::RST_ZERO;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        dts_pkg::OFS_TIMER_ENABLE: tmr_en_r <= {15'h0000, wd[0]};
        dts_pkg::OFS_TIMER_SRC: tmr_src_r <= {14'h0000, wd[1:0]}; // R4
        dts_pkg::OFS_TIMER_DUR: tmr_dur_r <= clamp16(wd, dts_pkg::DUR_MAX); // R5
        dts_pkg::OFS_AI1_LO: ai_lo_r <= clamp16(wd, ai_hi_r);
        dts_pkg::OFS_AI1_HI: ai_hi_r <= clamp16(clamp_lo(wd, ai_lo_r),
                                                dts_pkg::AI_V_MAX);
        dts_pkg::OFS_HS_THR: hs_thr_r <= wd;
        dts_pkg::OFS_FAN_MODE: fan_mode_r <= {15'h0000, wd[0]};
        dts_pkg::OFS_WAKE_FREQ: wake_f_r <= clamp_lo(wd, sleep_f_r);
        dts_pkg::OFS_WAKE_DLY: wake_d_r <= clamp16(wd, dts_pkg::DUR_MAX);
        dts_pkg::OFS_SLEEP_FREQ: sleep_f_r <= clamp16(wd, wake_f_r); // R13
        dts_pkg::OFS_SLEEP_DLY: sleep_d_r <= clamp16(wd, dts_pkg::DUR_MAX);
        dts_pkg::OFS_RUN_TARGET: run_tgt_r <= clamp16(wd, dts_pkg::DUR_MAX);
        dts_pkg::OFS_IRQ_MASK: irq_mask_r <= wd[8:0];
        default: ;
      endcase
    end
  end

  // read mux
  logic [15:0] rd_mux;
  always_comb begin
    case (paddr)
      dts_pkg::OFS_TIMER_ENABLE: rd_mux = tmr_en_r;
      dts_pkg::OFS_TIMER_SRC: rd_mux = tmr_src_r;
      dts_pkg::OFS_TIMER_DUR: rd_mux = tmr_dur_r;
      dts_pkg::OFS_AI1_LO: rd_mux = ai_lo_r;
      dts_pkg::OFS_AI1_HI: rd_mux = ai_hi_r;
      dts_pkg::OFS_HS_THR: rd_mux = hs_thr_r;
      dts_pkg::OFS_FAN_MODE: rd_mux = fan_mode_r;
      dts_pkg::OFS_WAKE_FREQ: rd_mux = wake_f_r;
      dts_pkg::OFS_WAKE_DLY: rd_mux = wake_d_r;
      dts_pkg::OFS_SLEEP_FREQ: rd_mux = sleep_f_r;
      dts_pkg::OFS_SLEEP_DLY: rd_mux = sleep_d_r;
      dts_pkg::OFS_RUN_TARGET: rd_mux = run_tgt_r;
      dts_pkg::OFS_REMAIN: rd_mux = remain_r; // R3
      dts_pkg::OFS_STATUS: rd_mux = {7'h00, fl_r};
      dts_pkg::OFS_IRQ_STAT: rd_mux = {7'h00, irq_stat_r};
      dts_pkg::OFS_IRQ_MASK: rd_mux = {7'h00, irq_mask_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // apb answer in the first access cycle, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? {16'h0000, rd_mux} : prdata;
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [31:0] pre_r;
  logic [5:0] min_div_r;
  logic tick_s_r, tick_m_r;

  // one tenth-second tick, and a tenth-minute tick every 60 of those
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 32'h0000_0000;
      min_div_r <= 6'h00;
      tick_s_r <= 1'b0;
      tick_m_r <= 1'b0;
    end else begin
      tick_s_r <= (pre_r == 32'(TICK_CYC - 1)); // R15
      pre_r <= (pre_r == 32'(TICK_CYC - 1)) ? 32'h0 : pre_r + 32'h1;
      tick_m_r <= 1'b0;
      if (tick_s_r) begin
        if (min_div_r == 6'(dts_pkg::TENTHS_PER_TENTH_MIN - 1)) begin
          min_div_r <= 6'h00;
          tick_m_r <= 1'b1; // R15
        end else begin
          min_div_r <= min_div_r + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // run control and counters
  // ----------------------------------------------------------------
  dts_pkg::dts_state_e st_r, st_nxt;
  logic [15:0] run_cnt_r, slp_cnt_r, wak_cnt_r;
  logic run_q_r, tdone_r;

  // scaled duration: value times percent over full scale
  wire [15:0] ai_sel = (tmr_src_r[1:0] == 2'd1) ? drv_r.ai1_pct :
                       (tmr_src_r[1:0] == 2'd2) ? drv_r.ai2_pct :
                       drv_r.ai3_pct;
  wire [31:0] scaled = 32'(tmr_dur_r) * 32'(clamp16(ai_sel,
                                                  dts_pkg::AI_FULL));
  wire [15:0] dur_eff = (tmr_src_r[1:0] == 2'd0) ? tmr_dur_r :
                        16'(scaled / 32'(dts_pkg::AI_FULL)); // R4
  wire start = drv_r.run && !run_q_r;
  wire dorm_en = (wake_f_r != 16'h0) || (sleep_f_r != 16'h0); // R12
  wire low_f = drv_r.set_freq <= sleep_f_r;
  wire high_f = drv_r.set_freq >= wake_f_r;
  wire sleep_hit = dorm_en && low_f && (slp_cnt_r >= sleep_d_r); // R10
  wire wake_hit = dorm_en && drv_r.run_cmd && high_f &&
                  (wak_cnt_r >= wake_d_r); // R11
  wire tmr_on = tmr_en_r[0]; // R1
  // the start cycle still sees the old count, so it must not stop the drive
  wire tmr_hit = tmr_on && drv_r.run && !start &&
                 (run_cnt_r >= dur_eff); // R2

  // supervisor state
  always_comb begin
    case (st_r)
      dts_pkg::ST_IDLE: begin
        st_nxt = drv_r.run ? dts_pkg::ST_RUN : dts_pkg::ST_IDLE;
      end
      dts_pkg::ST_RUN: begin
        if (sleep_hit && drv_r.run)
          st_nxt = dts_pkg::ST_DORMANT; // R10
        else if (!drv_r.run)
          st_nxt = dts_pkg::ST_IDLE;
        else
          st_nxt = dts_pkg::ST_RUN;
      end
      dts_pkg::ST_DORMANT: begin
        if (!dorm_en || !drv_r.run_cmd)
          st_nxt = dts_pkg::ST_IDLE;
        else if (wake_hit)
          st_nxt = dts_pkg::ST_IDLE; // R11
        else
          st_nxt = dts_pkg::ST_DORMANT;
      end
      default: st_nxt = dts_pkg::ST_IDLE;
    endcase
  end

  // counters and state update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= dts_pkg::ST_IDLE;
      run_q_r <= 1'b0;
      run_cnt_r <= 16'h0000;
      slp_cnt_r <= 16'h0000;
      wak_cnt_r <= 16'h0000;
      tdone_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      run_q_r <= drv_r.run;
      if (start)
        run_cnt_r <= 16'h0000; // R3
      else if (drv_r.run && tick_m_r && run_cnt_r != 16'hffff)
        run_cnt_r <= run_cnt_r + 16'h0001; // R14
      if (start)
        tdone_r <= 1'b0;
      else if (tmr_hit)
        tdone_r <= 1'b1;
      if (st_r != dts_pkg::ST_RUN || !low_f || !dorm_en)
        slp_cnt_r <= 16'h0000;
      else if (tick_s_r && slp_cnt_r != 16'hffff)
        slp_cnt_r <= slp_cnt_r + 16'h0001;
      if (st_r != dts_pkg::ST_DORMANT || !high_f || !drv_r.run_cmd)
        wak_cnt_r <= 16'h0000;
      else if (tick_s_r && wak_cnt_r != 16'hffff)
        wak_cnt_r <= wak_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // flags, remaining time, interrupts
  // ----------------------------------------------------------------
  dts_pkg::dts_flags_s fl_nxt;
  always_comb begin
    fl_nxt = '0;
    fl_nxt.timer_stop = tmr_hit; // R2
    fl_nxt.timing_reached = tmr_on && (tdone_r || tmr_hit); // R2
    fl_nxt.ai1_out_of_limit = (drv_r.ai1_volt > ai_hi_r) ||
                              (drv_r.ai1_volt < ai_lo_r); // R6
    fl_nxt.module_temp = drv_r.hs_temp >= hs_thr_r; // R7
    if (fan_mode_r[0])
      fl_nxt.fan_on = 1'b1; // R9
    else if (drv_r.run)
      fl_nxt.fan_on = 1'b1; // R8
    else if (drv_r.hs_temp > dts_pkg::FAN_TEMP)
      fl_nxt.fan_on = 1'b1; // R8
    else if (drv_r.hs_temp < dts_pkg::FAN_TEMP)
      fl_nxt.fan_on = 1'b0; // R8
    else
      fl_nxt.fan_on = fl_r.fan_on;
    fl_nxt.sleep_stop = (st_r == dts_pkg::ST_RUN) && sleep_hit; // R10
    fl_nxt.wake_start = (st_r == dts_pkg::ST_DORMANT) && wake_hit; // R11
    fl_nxt.dormant = st_r == dts_pkg::ST_DORMANT;
    fl_nxt.run_time_reached = drv_r.run && !start &&
                              (run_cnt_r >= run_tgt_r); // R14
  end

  wire [15:0] remain_nxt = !tmr_on ? 16'h0000 :
                           (run_cnt_r >= dur_eff) ? 16'h0000 :
                           dur_eff - run_cnt_r; // R3
  wire [8:0] ev = fl_nxt & ~fl_r;

  // flags, remaining time and sticky status; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_r <= '0;
      remain_r <= 16'h0000;
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      fl_r <= fl_nxt;
      remain_r <= remain_nxt;
      irq_stat_r <= ev | (stat_rd ? 9'h000 : irq_stat_r);
      irq <= |((ev | (stat_rd ? 9'h000 : irq_stat_r)) & irq_mask_r);
    end
  end

  assign flags_out = fl_r;

endmodule

`default_nettype wire

// file: inc/dts_pkg.sv
/*
  package for the drive timing supervisor: register offsets, reset values,
  field limits, time-base counts and carrier structs.
  assumes a 20 MHz pclk and a 32-bit apb slave port.
*/
package dts_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_ENABLE = 8'h00;
  localparam logic [7:0] OFS_TIMER_SRC = 8'h04;
  localparam logic [7:0] OFS_TIMER_DUR = 8'h08;
  localparam logic [7:0] OFS_AI1_LO = 8'h0c;
  localparam logic [7:0] OFS_AI1_HI = 8'h10;
  localparam logic [7:0] OFS_HS_THR = 8'h14;
  localparam logic [7:0] OFS_FAN_MODE = 8'h18;
  localparam logic [7:0] OFS_WAKE_FREQ = 8'h1c;
  localparam logic [7:0] OFS_WAKE_DLY = 8'h20;
  localparam logic [7:0] OFS_SLEEP_FREQ = 8'h24;
  localparam logic [7:0] OFS_SLEEP_DLY = 8'h28;
  localparam logic [7:0] OFS_RUN_TARGET = 8'h2c;
  localparam logic [7:0] OFS_REMAIN = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;

  // ----------------------------------------------------------------
  // reset values (voltages in 10 mv, temperature in degc)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_AI1_LO = 16'h0136; // 3.10 v
  localparam logic [15:0] RST_AI1_HI = 16'h02a8; // 6.80 v
  localparam logic [15:0] RST_HS_THR = 16'h004b; // 75 degc
  localparam logic [15:0] AI_V_MAX = 16'h03e8;   // 10.00 v
  localparam logic [15:0] DUR_MAX = 16'hfde8;    // 6500.0 in tenths
  localparam logic [15:0] FAN_TEMP = 16'h0028;   // 40 degc
  localparam logic [15:0] AI_FULL = 16'h03e8;    // 100.0 % in 0.1 %

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TENTH_SEC_MS = 100;
  localparam int TENTH_SEC_CYC = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int TENTHS_PER_TENTH_MIN = 60;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic run_cmd;
    logic [15:0] set_freq;
    logic [15:0] ai1_volt;
    logic [15:0] ai1_pct;
    logic [15:0] ai2_pct;
    logic [15:0] ai3_pct;
    logic [15:0] hs_temp;
  } dts_drive_s;

  typedef struct packed {
    logic timer_stop;
    logic timing_reached;
    logic ai1_out_of_limit;
    logic module_temp;
    logic fan_on;
    logic sleep_stop;
    logic wake_start;
    logic dormant;
    logic run_time_reached;
  } dts_flags_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DORMANT = 3'b100
  } dts_state_e;

endpackage

// file: testbench/dts_monitor.sv
/*
  checker for dts_top, bound to its ports.
  assumes 2-flop input sync plus a registered flag stage.
*/
`timescale 1ns/10ps
`default_nettype none
module dts_monitor #(
  parameter int TICK_CYC = dts_pkg::TENTH_SEC_CYC
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // drive side
  input wire dts_pkg::dts_drive_s drive_in,
  input wire dts_pkg::dts_flags_s flags_out,
  input wire logic irq
);
  logic [15:0] thr_r, lo_r, hi_r;
  logic wr_w, bad_w, oor_w;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the limit registers, from completed writes
  assign wr_w = psel & penable & pready & pwrite & ~pslverr;
  assign bad_w = (paddr > 8'h3c) | (paddr[1:0] != 2'b00);
  assign oor_w = (drive_in.ai1_volt > hi_r) | (drive_in.ai1_volt < lo_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_r <= dts_pkg::RST_HS_THR;
      lo_r <= dts_pkg::RST_AI1_LO;
      hi_r <= dts_pkg::RST_AI1_HI;
    end else if (wr_w) begin
      if (paddr == dts_pkg::OFS_HS_THR) thr_r <= pwdata[15:0];
      if (paddr == dts_pkg::OFS_AI1_LO) lo_r <= pwdata[15:0];
      if (paddr == dts_pkg::OFS_AI1_HI) hi_r <= pwdata[15:0];
    end
  end
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready not one cycle after setup");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_ADDR: assert property (psel && !penable && bad_w |=> pslverr)
    else $error("bad address without pslverr");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 0)
    else $error("upper read bits not zero");
  AST_STOP_REACH: assert property (
    $rose(flags_out.timer_stop) |-> flags_out.timing_reached)
    else $error("stop without timing reached");
  AST_AI1_WIN: assert property (
    ($stable(drive_in.ai1_volt) && $stable(lo_r) && $stable(hi_r))[*4]
    |-> flags_out.ai1_out_of_limit == oor_w)
    else $error("analog one window flag wrong");
  AST_MOD_TEMP: assert property (
    ($stable(drive_in.hs_temp) && $stable(thr_r))[*4]
    |-> flags_out.module_temp == (drive_in.hs_temp >= thr_r))
    else $error("module temperature flag wrong");
  AST_FAN_RUN: assert property (drive_in.run[*5] |-> flags_out.fan_on)
    else $error("fan off while running");
  COV_REACH: cover property ($rose(flags_out.timing_reached));
  COV_SLEEP: cover property ($rose(flags_out.dormant));
  COV_WAKE: cover property ($rose(flags_out.wake_start));
endmodule
bind dts_top dts_monitor #(.TICK_CYC(TICK_CYC)) u_dts_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive_in(drive_in),
  .flags_out(flags_out), .irq(irq));
`default_nettype wire

// file: testbench/dts_drive_model.sv
/*
  drive run control model: turns the run command and the block's
  stop and wake requests into the run level.
  assumes all other levels come straight from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module dts_drive_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wanted levels and the block's flags
  input wire dts_pkg::dts_drive_s want,
  input wire dts_pkg::dts_flags_s flags,
  // levels seen by the block
  output dts_pkg::dts_drive_s drive
);
  logic run_r, cmd_r, stop_r;
  logic stop_w, start_w;
  // stop acts on a rising request, so a lingering level cannot block a start
  assign stop_w = (flags.timer_stop | flags.sleep_stop) & ~stop_r;
  assign start_w = (want.run_cmd & ~cmd_r) | flags.wake_start;
  assign drive = {run_r, want[$bits(want)-2:0]};
  // run level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      cmd_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      cmd_r <= want.run_cmd;
      stop_r <= flags.timer_stop | flags.sleep_stop;
      if (start_w) run_r <= 1'b1;
      else if (stop_w | ~want.run_cmd) run_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
/*
  self-checking bench for dts_top over apb.
  assumes a 20-cycle tick, so a tenth of a minute is 1200 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TR = 7;
  localparam int AO = 6;
  localparam int MT = 5;
  localparam int FN = 4;
  localparam int DR = 1;
  localparam int RT = 0;
  localparam logic [7:0] OA [7] = '{dts_pkg::OFS_TIMER_ENABLE,
    dts_pkg::OFS_TIMER_SRC, dts_pkg::OFS_TIMER_DUR, dts_pkg::OFS_AI1_LO,
    dts_pkg::OFS_AI1_HI, dts_pkg::OFS_HS_THR, dts_pkg::OFS_FAN_MODE};
  localparam logic [15:0] RV [7] = '{16'h0000, 16'h0000, 16'h0000,
    16'h0136, 16'h02a8, 16'h004b, 16'h0000};
  localparam logic [15:0] AV [4] = '{16'h0100, 16'h0200, 16'h0300, 16'h0136};
  localparam logic [15:0] HV [3] = '{16'h004a, 16'h004b, 16'h0027};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [8:0] fl;
  dts_pkg::dts_drive_s want, drv;
  dts_pkg::dts_flags_s flags;
  int err_total, n_checks;
  assign fl = flags;
  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  dts_top #(.TICK_CYC(20)) u_dts_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_in(drv), .flags_out(flags), .irq(irq));
  dts_drive_model u_dts_drive_model (.clk(pclk), .rst_n(presetn),
    .want(want), .flags(flags), .drive(drv));
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int b, input int n);
    for (int i = 0; i < n && fl[b] !== 1'b1; i++) cyc(1);
  endtask
  task automatic restart();
    @(posedge pclk) want.run_cmd <= 1'b0;
    cyc(4);
    @(posedge pclk) want.run_cmd <= 1'b1;
    cyc(20);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    $display("[FAIL] watchdog expired");
    tally_and_finish();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    want = '0;
    want.ai1_volt = 16'h0200;
    want.hs_temp = 16'h0020;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (OA[i]) begin
      xfer(0, OA[i], 0);
      chk("reset value", RV[i], rv);
    end
    xfer(0, 8'h40, 0);
    chk("bad addr err", 1, ev);
    chk("bad addr data", 0, rv);
    xfer(1, dts_pkg::OFS_TIMER_DUR, 32'hffff);
    xfer(0, dts_pkg::OFS_TIMER_DUR, 0);
    chk("duration clamp", 32'hfde8, rv);
    foreach (AV[i]) begin
      @(posedge pclk) want.ai1_volt <= AV[i];
      cyc(6);
      chk("ai1 window", 4'b0101 >> i & 1, fl[AO]);
    end
    foreach (HV[i]) begin
      @(posedge pclk) want.hs_temp <= HV[i];
      cyc(6);
      chk("module temp", 3'b010 >> i & 1, fl[MT]);
      chk("fan stopped", 3'b011 >> i & 1, fl[FN]);
    end
    xfer(1, dts_pkg::OFS_FAN_MODE, 1);
    cyc(6);
    chk("fan mode 1", 1, fl[FN]);
    xfer(1, dts_pkg::OFS_FAN_MODE, 0);
    xfer(1, dts_pkg::OFS_TIMER_DUR, 2);
    xfer(1, dts_pkg::OFS_RUN_TARGET, 1);
    xfer(1, dts_pkg::OFS_TIMER_ENABLE, 1);
    @(posedge pclk) want.run_cmd <= 1'b1;
    cyc(1300);
    chk("run time", 1, fl[RT]);
    xfer(0, dts_pkg::OFS_REMAIN, 0);
    chk("remaining", 1, rv);
    wt(TR, 1500);
    chk("timing reached", 1, fl[TR]);
    cyc(5);
    chk("drive stopped", 0, drv.run);
    chk("irq masked", 0, irq);
    xfer(1, dts_pkg::OFS_IRQ_MASK, 32'h80);
    cyc(3);
    chk("irq raised", 1, irq);
    xfer(0, dts_pkg::OFS_IRQ_STAT, 0);
    chk("irq status", 1, rv[7]);
    cyc(3);
    chk("irq cleared", 0, irq);
    xfer(1, dts_pkg::OFS_TIMER_SRC, 1);
    @(posedge pclk) want.ai1_pct <= 16'd500;
    restart();
    chk("scaled running", 1, drv.run);
    xfer(0, dts_pkg::OFS_REMAIN, 0);
    chk("scaled remaining", 1, rv);
    cyc(1250);
    chk("scaled stop", 0, drv.run);
    xfer(1, dts_pkg::OFS_TIMER_ENABLE, 0);
    restart();
    cyc(2600);
    chk("timer off", 0, fl[TR]);
    chk("still running", 1, drv.run);
    chk("no dormant", 0, fl[DR]);
    @(posedge pclk) want.set_freq <= 16'd120;
    cyc(6);
    xfer(1, dts_pkg::OFS_WAKE_FREQ, 100);
    xfer(1, dts_pkg::OFS_SLEEP_FREQ, 50);
    xfer(1, dts_pkg::OFS_WAKE_DLY, 1);
    xfer(1, dts_pkg::OFS_SLEEP_DLY, 1);
    cyc(60);
    chk("no early dormant", 0, fl[DR]);
    @(posedge pclk) want.set_freq <= 16'd40;
    wt(DR, 100);
    chk("dormant", 1, fl[DR]);
    cyc(3);
    chk("dormant stop", 0, drv.run);
    @(posedge pclk) want.set_freq <= 16'd120;
    for (int i = 0; i < 100 && drv.run !== 1'b1; i++) cyc(1);
    chk("wakeup", 1, drv.run);
    tally_and_finish();
  end
endmodule
`default_nettype wire
